/* hw/ufst_params.svh */
// Constants of the serial port format, status, test and pin-sharing block
// Included by ufst_pkg and ufst_top; definitions only
// Behaviour
// - Flow-ignore set: transmit regardless of RTS
// - Flow-ignore clear: start only while RTS asserted
// - CTS source set: CTS deasserts when receive full
// - CTS source clear: CTS pin is inverse drive
// - Parity-on enables generator and checker; default off
// - Parity sense: 0 even, 1 odd
// - Transmit one or two stops; receiver accepts one
// - Character size: 0 eight bits, 1 seven
// - Clock source: 0 divider, 1 external pin
// - Internal 16x tick every divider_field+1 clocks
// - Status read-only except change flag write-one-clear
// - Transmitter-empty sets when drained; write clears
// - Transmit-ready: sets while unsent count below transmit threshold, clears above it
// - Receive-ready: sets while unread count above receive threshold, clears below it
// - Change flag sets on any RTS edge
// - Status reports present RTS pin level
// - Force-bad-parity inverts sent parity bit
// - Loopback feeds receiver from transmitter output
// - Infrared loopback feeds infrared receiver from transmitter
// - Pin-function bit: 0 general I/O, 1 serial
// - Direction bit: 0 input, 1 output
// - Pin data latches writes; reads mix pins
// - Threshold codes: 1, 4, 8, 14 slots
`ifndef UFST_PARAMS_SVH
`define UFST_PARAMS_SVH
`define UFST_IDX_PRIMARY 4'h0
`define UFST_IDX_LINE 4'h1
`define UFST_IDX_DIVIDER 4'h2
`define UFST_IDX_STATUS 4'h3
`define UFST_IDX_TEST 4'h4
`define UFST_IDX_PIN_FUNC 4'h5
`define UFST_IDX_PIN_DIR 4'h6
`define UFST_IDX_PIN_DATA 4'h7
`define UFST_IDX_TX_DATA 4'h8
`define UFST_IDX_RX_DATA 4'h9
`define UFST_MASK_PRIMARY 16'hcc80
`define UFST_MASK_LINE 16'h71f0
`define UFST_MASK_DIVIDER 16'h0fff
`define UFST_MASK_TEST 16'h3400
`define UFST_MASK_PIN 16'h000f
`define UFST_RST_REG 16'h0000
`define UFST_B_TX_THR 14
`define UFST_B_RX_THR 10
`define UFST_B_IR_EN 7
`define UFST_B_FLOW_IGNORE 14
`define UFST_B_CTS_SRC 13
`define UFST_B_CTS_DRIVE 12
`define UFST_B_PARITY_ON 8
`define UFST_B_PARITY_SENSE 7
`define UFST_B_STOP_COUNT 6
`define UFST_B_CHAR_SIZE 5
`define UFST_B_CLK_SRC 4
`define UFST_B_TX_EMPTY 15
`define UFST_B_RTS_LEVEL 14
`define UFST_B_TX_READY 13
`define UFST_B_RTS_CHANGE 12
`define UFST_B_RX_READY 9
`define UFST_B_FORCE_PAR 13
`define UFST_B_LOOP 12
`define UFST_B_IR_LOOP 10
`define UFST_B_RX_VALID 15
`define UFST_B_RX_ERR 14
`define UFST_B_RX_FRAME 12
`define UFST_B_RX_PARITY 10
`define UFST_SUB_MID 4'h7
`define UFST_SUB_LAST 4'hf
`define UFST_LAST_BIT7 3'h6
`define UFST_LAST_BIT8 3'h7
`define UFST_THR_CODE0 5'h01
`define UFST_THR_CODE1 5'h04
`define UFST_THR_CODE2 5'h08
`define UFST_THR_CODE3 5'h0e
`define UFST_SERIAL_OE 4'h9
`endif

/* hw/ufst_pkg.sv */
// Types and shared decode functions of the serial port block
// Assumes ufst_params.svh is reachable by bare name
package ufst_pkg;
  `include "ufst_params.svh"

  typedef logic [15:0] ufst_word_t;
  typedef logic [3:0] ufst_addr_t;
  typedef logic [3:0] ufst_pins_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ufst_tx_state_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ufst_rx_state_e;

  // Threshold code to slot count
  function automatic logic [4:0] ufst_slots(input logic [1:0] code);
    logic [4:0] n;
    n = `UFST_THR_CODE0;
    case (code)
      2'h1: n = `UFST_THR_CODE1;
      2'h2: n = `UFST_THR_CODE2;
      2'h3: n = `UFST_THR_CODE3;
      default: n = `UFST_THR_CODE0;
    endcase
    return n;
  endfunction

  // Parity bit for a character; bit 7 excluded in seven-bit mode
  function automatic logic ufst_parity(input logic [7:0] data, input logic seven, input logic odd);
    return (^{data[7] & ~seven, data[6:0]}) ^ odd;
  endfunction
endpackage

/* hw/ufst_fifo.sv */
// Character FIFO with registered head word
// Assumes DEPTH is a power of two and CW can hold DEPTH
`timescale 1ns/1ns
`default_nettype none
module ufst_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16,
  parameter int CW = 5
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic push,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic pop,
  output logic [WIDTH-1:0] head_q,
  output logic [CW-1:0] count_q,
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [AW-1:0] rptr_d;
  logic do_push;
  logic do_pop;

  assign full = (count_q == CW'(DEPTH));
  assign empty = (count_q == '0);
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign rptr_d = do_pop ? rptr_q + 1'b1 : rptr_q;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wptr_q] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
    end else begin
      if (do_push) begin
        wptr_q <= wptr_q + 1'b1;
      end
      rptr_q <= rptr_d;
      count_q <= count_q + CW'(do_push) - CW'(do_pop);
    end
  end

  // Bypass so a word written into an empty slot appears at once
  always_ff @(posedge clk) begin
    if (reset) begin
      head_q <= '0;
    end else if (do_push && wptr_q == rptr_d) begin
      head_q <= wdata;
    end else begin
      head_q <= mem[rptr_d];
    end
  end
endmodule
`default_nettype wire

/* hw/ufst_top.sv */
// Serial port format, status, test and pin-sharing logic with 16x serial engine
// Assumes synchronous pin inputs and a plain register port with one-cycle strobes
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "ufst_params.svh"
module ufst_top #(
  parameter int DEPTH = 16,
  parameter int CW = 5
) (
  input wire logic clk,
  input wire logic reset,
  input wire ufst_pkg::ufst_addr_t reg_addr,
  input wire ufst_pkg::ufst_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output ufst_pkg::ufst_word_t reg_rdata_q,
  input wire ufst_pkg::ufst_pins_t pin_in,
  output ufst_pkg::ufst_pins_t pin_out,
  output ufst_pkg::ufst_pins_t pin_oe,
  input wire logic external_clock_pin,
  input wire logic ir_rx_in,
  output logic ir_tx_out
);
  import ufst_pkg::*;

  ufst_word_t prim_q, line_q, div_q, test_q, pfn_q, pdir_q, pdata_q;
  ufst_word_t status_w;
  logic flow_ignore, cts_source_select, cts_drive, parity_on, parity_sense;
  logic stop_count, char_size, bit_clock_source, force_bad_parity, loopback;
  logic infrared_loopback, ir_en;
  logic [11:0] divider_field;
  logic [11:0] div_cnt_q;
  logic ext_q, ext_prev_q, tick_int, tick;
  logic rts_now, rts_prev_q, rts_change_flag_q, rts_clear;
  logic transmitter_empty_q, transmit_ready_q, receive_ready_q;
  logic [4:0] tx_thr, rx_thr;
  logic tx_push, tx_pop, tx_go, tx_full, tx_empty;
  logic [7:0] tx_head;
  logic [CW-1:0] tx_cnt;
  logic rx_push, rx_pop, rx_full, rx_empty;
  logic [9:0] rx_head;
  logic [9:0] rx_word;
  logic [CW-1:0] rx_cnt;
  ufst_tx_state_e tx_q;
  ufst_rx_state_e rx_q;
  logic [3:0] tx_sub_q, rx_sub_q;
  logic [2:0] tx_bit_q, rx_bit_q, last_bit;
  logic [7:0] tx_shift_q, rx_shift_q, rx_data;
  logic tx_par_q, tx_stop_q, tx_line_q, rx_perr_q, rx_line, ir_rx_eff, cts_n;
  logic tx_end, rx_end;
  ufst_pins_t serial_out;

  assign flow_ignore = line_q[`UFST_B_FLOW_IGNORE];
  assign cts_source_select = line_q[`UFST_B_CTS_SRC];
  assign cts_drive = line_q[`UFST_B_CTS_DRIVE];
  assign parity_on = line_q[`UFST_B_PARITY_ON];
  assign parity_sense = line_q[`UFST_B_PARITY_SENSE];
  assign stop_count = line_q[`UFST_B_STOP_COUNT];
  assign char_size = line_q[`UFST_B_CHAR_SIZE];
  assign bit_clock_source = line_q[`UFST_B_CLK_SRC];
  assign divider_field = div_q[11:0];
  assign force_bad_parity = test_q[`UFST_B_FORCE_PAR];
  assign loopback = test_q[`UFST_B_LOOP];
  assign infrared_loopback = test_q[`UFST_B_IR_LOOP];
  assign ir_en = prim_q[`UFST_B_IR_EN];
  assign tx_thr = ufst_slots(prim_q[`UFST_B_TX_THR +: 2]);
  assign rx_thr = ufst_slots(prim_q[`UFST_B_RX_THR +: 2]);
  assign last_bit = char_size ? `UFST_LAST_BIT7 : `UFST_LAST_BIT8;

  // Register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      prim_q <= `UFST_RST_REG;
      line_q <= `UFST_RST_REG;
      div_q <= `UFST_RST_REG;
      test_q <= `UFST_RST_REG;
      pfn_q <= `UFST_RST_REG;
      pdir_q <= `UFST_RST_REG;
      pdata_q <= `UFST_RST_REG;
    end else if (reg_wr) begin
      if (reg_addr == `UFST_IDX_PRIMARY) begin
        prim_q <= reg_wdata & `UFST_MASK_PRIMARY;
      end else if (reg_addr == `UFST_IDX_LINE) begin
        line_q <= reg_wdata & `UFST_MASK_LINE;
      end else if (reg_addr == `UFST_IDX_DIVIDER) begin
        div_q <= reg_wdata & `UFST_MASK_DIVIDER;
      end else if (reg_addr == `UFST_IDX_TEST) begin
        test_q <= reg_wdata & `UFST_MASK_TEST;
      end else if (reg_addr == `UFST_IDX_PIN_FUNC) begin
        pfn_q <= reg_wdata & `UFST_MASK_PIN;
      end else if (reg_addr == `UFST_IDX_PIN_DIR) begin
        pdir_q <= reg_wdata & `UFST_MASK_PIN;
      end else if (reg_addr == `UFST_IDX_PIN_DATA) begin
        pdata_q <= reg_wdata & `UFST_MASK_PIN;
      end
    end
  end

  // 16x bit clock: divider or external pin edge
  always_ff @(posedge clk) begin
    if (reset) begin
      ext_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_q <= external_clock_pin;
      ext_prev_q <= ext_q;
    end
  end

  assign tick_int = (div_cnt_q >= divider_field);

  always_ff @(posedge clk) begin
    if (reset || tick_int) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + 12'h001;
    end
  end

  assign tick = bit_clock_source ? (ext_q && !ext_prev_q) : tick_int;

  // Pin sharing
  assign rts_now = pfn_q[2] ? pin_in[2] : 1'b1;
  assign cts_n = cts_source_select ? rx_full : !cts_drive;
  assign serial_out = {cts_n, 1'b1, 1'b1, ir_en ? 1'b1 : tx_line_q};
  assign pin_out = (pfn_q[3:0] & serial_out) | (~pfn_q[3:0] & pdata_q[3:0]);
  assign pin_oe = (pfn_q[3:0] & `UFST_SERIAL_OE) | (~pfn_q[3:0] & pdir_q[3:0]);
  assign ir_tx_out = ir_en && !tx_line_q;
  assign ir_rx_eff = infrared_loopback ? ir_tx_out : ir_rx_in;
  always_comb begin
    if (loopback) begin
      rx_line = tx_line_q;
    end else if (ir_en) begin
      rx_line = !ir_rx_eff;
    end else begin
      rx_line = pfn_q[1] ? pin_in[1] : 1'b1;
    end
  end

  // Character FIFOs
  assign tx_push = reg_wr && reg_addr == `UFST_IDX_TX_DATA;
  assign rx_pop = reg_rd && reg_addr == `UFST_IDX_RX_DATA;
  assign tx_go = !tx_empty && (flow_ignore || !rts_now);
  assign tx_pop = tick && tx_q == TX_IDLE && tx_go;
  assign tx_end = (tx_sub_q == `UFST_SUB_LAST);
  assign rx_end = (rx_sub_q == `UFST_SUB_LAST);
  assign rx_data = char_size ? {1'b0, rx_shift_q[7:1]} : rx_shift_q;
  assign rx_push = tick && rx_q == RX_STOP && rx_end;
  assign rx_word = {!rx_line, rx_perr_q, rx_data};

  ufst_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_tx_fifo (
    .clk(clk),
    .reset(reset),
    .push(tx_push),
    .wdata(reg_wdata[7:0]),
    .pop(tx_pop),
    .head_q(tx_head),
    .count_q(tx_cnt),
    .full(tx_full),
    .empty(tx_empty)
  );

  ufst_fifo #(.WIDTH(10), .DEPTH(DEPTH), .CW(CW)) u_rx_fifo (
    .clk(clk),
    .reset(reset),
    .push(rx_push),
    .wdata(rx_word),
    .pop(rx_pop),
    .head_q(rx_head),
    .count_q(rx_cnt),
    .full(rx_full),
    .empty(rx_empty)
  );

  // Transmitter
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_q <= TX_IDLE;
      tx_sub_q <= '0;
      tx_bit_q <= '0;
      tx_shift_q <= '0;
      tx_par_q <= 1'b0;
      tx_stop_q <= 1'b0;
      tx_line_q <= 1'b1;
    end else if (tick) begin
      if (tx_q != TX_IDLE) begin
        tx_sub_q <= tx_sub_q + 4'h1;
      end
      case (tx_q)
        TX_IDLE: begin
          if (tx_go) begin
            tx_q <= TX_START;
            tx_shift_q <= tx_head;
            tx_par_q <= ufst_parity(tx_head, char_size, parity_sense) ^ force_bad_parity;
            tx_sub_q <= '0;
            tx_bit_q <= '0;
            tx_stop_q <= 1'b0;
            tx_line_q <= 1'b0;
          end
        end
        TX_START: begin
          if (tx_end) begin
            tx_q <= TX_DATA;
            tx_line_q <= tx_shift_q[0];
          end
        end
        TX_DATA: begin
          if (tx_end && tx_bit_q == last_bit) begin
            tx_q <= parity_on ? TX_PAR : TX_STOP;
            tx_line_q <= parity_on ? tx_par_q : 1'b1;
          end else if (tx_end) begin
            tx_bit_q <= tx_bit_q + 3'h1;
            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
            tx_line_q <= tx_shift_q[1];
          end
        end
        TX_PAR: begin
          if (tx_end) begin
            tx_q <= TX_STOP;
            tx_line_q <= 1'b1;
          end
        end
        TX_STOP: begin
          if (tx_end && stop_count && !tx_stop_q) begin
            tx_stop_q <= 1'b1;
          end else if (tx_end) begin
            tx_q <= TX_IDLE;
          end
        end
        default: tx_q <= TX_IDLE;
      endcase
    end
  end

  // Receiver: start qualified at mid-bit, then one sample per bit
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_q <= RX_IDLE;
      rx_sub_q <= '0;
      rx_bit_q <= '0;
      rx_shift_q <= '0;
      rx_perr_q <= 1'b0;
    end else if (tick) begin
      rx_sub_q <= rx_sub_q + 4'h1;
      case (rx_q)
        RX_IDLE: begin
          rx_sub_q <= '0;
          if (!rx_line) begin
            rx_q <= RX_START;
          end
        end
        RX_START: begin
          if (rx_sub_q == `UFST_SUB_MID) begin
            rx_q <= rx_line ? RX_IDLE : RX_DATA;
            rx_sub_q <= '0;
            rx_bit_q <= '0;
            rx_perr_q <= 1'b0;
          end
        end
        RX_DATA: begin
          if (rx_end) begin
            rx_shift_q <= {rx_line, rx_shift_q[7:1]};
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == last_bit) begin
              rx_q <= parity_on ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rx_end) begin
            rx_perr_q <= rx_line != ufst_parity(rx_data, char_size, parity_sense);
            rx_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_end) begin
            rx_q <= RX_IDLE;
          end
        end
        default: rx_q <= RX_IDLE;
      endcase
    end
  end

  // Status flags
  assign rts_clear = reg_wr && reg_addr == `UFST_IDX_STATUS && reg_wdata[`UFST_B_RTS_CHANGE];

  always_ff @(posedge clk) begin
    if (reset) begin
      rts_prev_q <= 1'b1;
      rts_change_flag_q <= 1'b0;
    end else begin
      rts_prev_q <= rts_now;
      if (rts_now != rts_prev_q) begin
        rts_change_flag_q <= 1'b1;
      end else if (rts_clear) begin
        rts_change_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      transmitter_empty_q <= 1'b0;
    end else if (tx_push) begin
      transmitter_empty_q <= 1'b0;
    end else if (tx_empty && tx_q == TX_IDLE) begin
      transmitter_empty_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      transmit_ready_q <= 1'b0;
      receive_ready_q <= 1'b0;
    end else begin
      if (tx_cnt < CW'(tx_thr)) begin
        transmit_ready_q <= 1'b1;
      end else if (tx_cnt > CW'(tx_thr)) begin
        transmit_ready_q <= 1'b0;
      end
      if (rx_cnt > CW'(rx_thr)) begin
        receive_ready_q <= 1'b1;
      end else if (rx_cnt < CW'(rx_thr)) begin
        receive_ready_q <= 1'b0;
      end
    end
  end

  always_comb begin
    status_w = '0;
    status_w[`UFST_B_TX_EMPTY] = transmitter_empty_q;
    status_w[`UFST_B_RTS_LEVEL] = rts_now;
    status_w[`UFST_B_TX_READY] = transmit_ready_q;
    status_w[`UFST_B_RTS_CHANGE] = rts_change_flag_q;
    status_w[`UFST_B_RX_READY] = receive_ready_q;
  end

  // Read data: valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset || !reg_rd) begin
      reg_rdata_q <= '0;
    end else if (reg_addr == `UFST_IDX_PRIMARY) begin
      reg_rdata_q <= prim_q;
    end else if (reg_addr == `UFST_IDX_LINE) begin
      reg_rdata_q <= line_q;
    end else if (reg_addr == `UFST_IDX_DIVIDER) begin
      reg_rdata_q <= div_q;
    end else if (reg_addr == `UFST_IDX_STATUS) begin
      reg_rdata_q <= status_w;
    end else if (reg_addr == `UFST_IDX_TEST) begin
      reg_rdata_q <= test_q;
    end else if (reg_addr == `UFST_IDX_PIN_FUNC) begin
      reg_rdata_q <= pfn_q;
    end else if (reg_addr == `UFST_IDX_PIN_DIR) begin
      reg_rdata_q <= pdir_q;
    end else if (reg_addr == `UFST_IDX_PIN_DATA) begin
      reg_rdata_q <= {12'h000, (pin_in & ~pdir_q[3:0]) | (pdata_q[3:0] & pdir_q[3:0])};
    end else if (reg_addr == `UFST_IDX_RX_DATA && !rx_empty) begin
      reg_rdata_q <= {1'b1, rx_head[9] | rx_head[8], 1'b0, rx_head[9], 1'b0, rx_head[8], 2'b00, rx_head[7:0]};
    end else begin
      reg_rdata_q <= '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_FLOW_IGNORE: assert property (
    tick && tx_q == TX_IDLE && !tx_empty && flow_ignore |=> tx_q == TX_START && !tx_line_q)
    else $error("Transmitter did not start with flow ignored");
  AST_FLOW_HOLD: assert property (
    tx_q == TX_IDLE && !flow_ignore && rts_now |=> tx_q == TX_IDLE)
    else $error("Transmitter started while RTS deasserted");
  AST_CTS_AUTO: assert property (
    cts_source_select && pfn_q[3] |-> pin_out[3] == rx_full && pin_oe[3])
    else $error("CTS pin not following receive full");
  AST_CTS_DRIVE: assert property (
    !cts_source_select && pfn_q[3] |-> pin_out[3] == !cts_drive)
    else $error("CTS pin not following drive bit");
  AST_NO_PARITY: assert property (
    tick && tx_q == TX_DATA && tx_end && tx_bit_q == last_bit && !parity_on |=> tx_q == TX_STOP && tx_line_q)
    else $error("Parity slot sent with parity off");
  AST_DIVIDER: assert property (
    !bit_clock_source && tick |=> div_cnt_q == 12'h000 && (!tick || divider_field == 12'h000))
    else $error("Divider count not restarted after tick");
  AST_EMPTY_CLEAR: assert property (
    tx_push |=> !transmitter_empty_q)
    else $error("Transmitter-empty not cleared by write");
  AST_RTS_EDGE: assert property (
    rts_now != $past(rts_now) |=> rts_change_flag_q ##1 (rts_change_flag_q || $past(rts_clear)))
    else $error("RTS change flag missing after edge");
  AST_RTS_STICKY: assert property (
    rts_change_flag_q && !rts_clear |=> rts_change_flag_q)
    else $error("RTS change flag lost without clear");
  AST_LOOPBACK: assert property (
    loopback && tx_q == TX_START |-> !rx_line)
    else $error("Loopback receiver not fed by transmitter");
  AST_GPIO_OUT: assert property (
    !pfn_q[0] |-> pin_out[0] == pdata_q[0] && pin_oe[0] == pdir_q[0])
    else $error("General I/O pin not driven by latch");

  COV_PARITY_SENT: cover property (tick && tx_q == TX_PAR && tx_end);
  COV_RX_PUSH: cover property (rx_push && !rx_full);
  COV_RTS_CLEAR: cover property (rts_change_flag_q ##1 rts_clear ##1 !rts_change_flag_q);
endmodule
`default_nettype wire

/* dv/ufst_term.sv */
// Remote serial terminal model: RTS handshake, frame capture and frame send
// Assumes one bench process calls its tasks at a time; BIT clocks per serial bit
`timescale 1ns/1ns
`default_nettype none
module ufst_term #(
  parameter int BIT = 32
) (
  input wire logic clk,
  input wire logic txd,
  output logic rxd,
  output logic rts_n
);
  int cyc = 0;
  initial begin
    rxd = 1'b1;
    rts_n = 1'b1;
  end
  always @(negedge clk) cyc <= cyc + 1;
  // Low level permits the port to send
  task automatic set_rts(input logic v);
    @(posedge clk);
    rts_n <= v;
  endtask
  task automatic hold_rxd(input logic v);
    @(posedge clk);
    rxd <= v;
  endtask
  // Samples n bits after the start bit, mid bit; unsampled bits read 1
  task automatic capture(input int n, output logic [10:0] f, output int t0);
    int w;
    w = 0;
    f = '1;
    while (txd !== 1'b0 && w < 4000) begin
      @(negedge clk);
      w++;
    end
    t0 = cyc;
    repeat (BIT / 2) @(negedge clk);
    for (int k = 0; k < n; k++) begin
      repeat (BIT) @(negedge clk);
      f[k] = txd;
    end
  endtask
  task automatic send(input logic [10:0] f, input int n);
    @(posedge clk);
    rxd <= 1'b0;
    for (int k = 0; k < n; k++) begin
      repeat (BIT) @(posedge clk);
      rxd <= f[k];
    end
    repeat (BIT) @(posedge clk);
    rxd <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* dv/ufst_top_test.sv */
// Self-checking bench of the serial format, status, test and pin block
// Assumes ufst_term as far side; divider field 1 gives 32 clocks a bit
`timescale 1ns/1ns
`default_nettype none
module ufst_top_test;
  import ufst_pkg::*;
  localparam int BIT = 32;
  logic clk = 1'b0;
  logic reset = 1'b1;
  ufst_addr_t reg_addr = '0;
  ufst_word_t reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  ufst_word_t reg_rdata_q;
  ufst_pins_t pin_out;
  ufst_pins_t pin_oe;
  ufst_pins_t pin_in;
  wire logic rxd;
  wire logic rts_n;
  logic ext_clk = 1'b0;
  logic ir_rx = 1'b0;
  logic ir_tx;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [10:0] fa, fb, ea, eb;
  int ta, tb, n;
  logic [4:0] cfg [4] = '{5'h00, 5'h16, 5'h18, 5'h1f};
  ufst_addr_t idx [6] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'ha};
  // Pad level: driver wins, else far side, idle pads pulled high
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & {1'b1, rts_n, rxd, 1'b1});
  ufst_top dut_u (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .external_clock_pin(ext_clk), .ir_rx_in(ir_rx),
    .ir_tx_out(ir_tx));
  ufst_term #(.BIT(BIT)) term_u (.clk(clk), .txd(pin_in[0]), .rxd(rxd), .rts_n(rts_n));
  always #4 clk = ~clk;
  // Free-running external 16x clock, one rising edge every two clocks
  always @(posedge clk) ext_clk <= ~ext_clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input ufst_addr_t a, input ufst_word_t d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input ufst_addr_t a, input ufst_word_t m, input ufst_word_t e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata_q & m, e);
    @(posedge clk);
  endtask
  // Line bits after the start bit; c: parity, odd, two stops, seven bits, forced
  function automatic logic [10:0] frame(input logic [7:0] d, input logic [4:0] c, output int n);
    logic [10:0] f;
    f = '1;
    n = c[1] ? 7 : 8;
    for (int k = 0; k < n; k++) f[k] = d[k];
    if (c[4]) begin
      f[n] = (^(d & (c[1] ? 8'h7f : 8'hff))) ^ c[3] ^ c[0];
      n++;
    end
    n += c[2] ? 2 : 1;
    return f;
  endfunction
  task automatic end_of_test();
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    foreach (idx[i]) rd(idx[i], 16'hffff, 16'h0000);
    rd(4'h3, 16'hffff, 16'he000);
    wr(4'h3, 16'hffff);
    rd(4'h3, 16'hffff, 16'he000);
    rd(4'h7, 16'hffff, 16'h000f);
    wr(4'h6, 16'h0003);
    wr(4'h7, 16'h0005);
    chk({8'h00, pin_oe, pin_out & pin_oe}, 16'h0031);
    rd(4'h7, 16'hffff, 16'h000d);
    wr(4'h2, 16'hffff);
    rd(4'h2, 16'hffff, 16'h0fff);
    wr(4'h2, 16'h0001);
    wr(4'h5, 16'h000f);
    chk({12'h000, pin_oe}, 16'h0009);
    // Held off until the far side lowers RTS
    wr(4'h8, 16'h0055);
    repeat (300) @(posedge clk);
    chk({15'h0000, pin_in[0]}, 16'h0001);
    rd(4'h3, 16'h8000, 16'h0000);
    term_u.set_rts(1'b0);
    term_u.capture(9, fa, ta);
    chk({5'h00, fa}, {5'h00, frame(8'h55, 5'h00, n)});
    @(posedge clk);
    rd(4'h3, 16'h5000, 16'h1000);
    wr(4'h3, 16'h1000);
    rd(4'h3, 16'h1000, 16'h0000);
    term_u.set_rts(1'b1);
    foreach (cfg[i]) begin
      wr(4'h1, 16'h4000 | {7'h00, cfg[i][4:1], 5'h00});
      wr(4'h4, cfg[i][0] ? 16'h2000 : 16'h0000);
      ea = frame(8'ha5, cfg[i], n);
      eb = frame(8'h3c, cfg[i], n);
      fork
        begin
          term_u.capture(n, fa, ta);
          term_u.capture(n, fb, tb);
        end
        begin
          wr(4'h8, 16'h00a5);
          wr(4'h8, 16'h003c);
        end
      join
      chk({5'h00, fa}, {5'h00, ea});
      chk({5'h00, fb}, {5'h00, eb});
      // One idle tick between back-to-back frames
      chk(16'(tb - ta), 16'(BIT * (n + 1) + BIT / 16));
      repeat (BIT) @(posedge clk);
      rd(4'h3, 16'h8000, 16'h8000);
    end
    wr(4'h4, 16'h0000);
    wr(4'h1, 16'h4100);
    term_u.send(frame(8'h81, 5'h10, n) ^ 11'h100, 10);
    repeat (20) @(posedge clk);
    rd(4'h9, 16'hffff, 16'hc481);
    // Loopback fill with a dead receive pad and deepest thresholds
    wr(4'h0, 16'hcc00);
    wr(4'h1, 16'h6000);
    wr(4'h4, 16'h1000);
    term_u.hold_rxd(1'b0);
    for (int i = 0; i < 16; i++) wr(4'h8, 16'h0010 + 16'(i));
    rd(4'h3, 16'ha000, 16'h0000);
    repeat (5600) @(posedge clk);
    rd(4'h3, 16'ha200, 16'ha200);
    chk({15'h0000, pin_out[3]}, 16'h0001);
    for (int i = 0; i < 16; i++) begin
      rd(4'h9, 16'hffff, 16'h8010 + 16'(i));
      if (i == 0) chk({15'h0000, pin_out[3]}, 16'h0000);
      if (i < 3) rd(4'h3, 16'h0200, i < 2 ? 16'h0200 : 16'h0000);
    end
    term_u.hold_rxd(1'b1);
    wr(4'h4, 16'h0000);
    wr(4'h1, 16'h1000);
    chk({15'h0000, pin_out[3]}, 16'h0000);
    wr(4'h1, 16'h0000);
    chk({15'h0000, pin_out[3]}, 16'h0001);
    // External clock keeps the bit rate although the divider is slower
    wr(4'h2, 16'h0003);
    wr(4'h1, 16'h4010);
    fork
      term_u.capture(9, fa, ta);
      wr(4'h8, 16'h005a);
    join
    chk({5'h00, fa}, {5'h00, frame(8'h5a, 5'h00, n)});
    repeat (BIT) @(posedge clk);
    // Infrared loop with light forced on the receive input
    wr(4'h1, 16'h4000);
    wr(4'h4, 16'h0400);
    wr(4'h0, 16'h0080);
    ir_rx <= 1'b1;
    chk({15'h0000, ir_tx}, 16'h0000);
    wr(4'h8, 16'h0069);
    repeat (6) @(posedge clk);
    chk({15'h0000, ir_tx}, 16'h0001);
    repeat (800) @(posedge clk);
    rd(4'h9, 16'hffff, 16'h8069);
    end_of_test();
  end
endmodule
`default_nettype wire
